// ---- rtl/can_rx_consts.svh ----
`ifndef CAN_RX_CONSTS_SVH
`define CAN_RX_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define FILT_STD_BASE 8'h00
`define FILT_STD_LAST 8'h3C
`define FILT_EXT_BASE 8'h40
`define FILT_EXT_LAST 8'h7C
`define MASK_STD_BASE 8'h80
`define MASK_STD_LAST 8'h88
`define MASK_EXT_BASE 8'h90
`define MASK_EXT_LAST 8'h98
`define MASK_SEL_OFF 8'hA0
`define OVF_LOW_OFF 8'hA4
`define OVF_HIGH_OFF 8'hA8
`define IRQ_STATUS_OFF 8'hB0
`define IRQ_ENABLE_OFF 8'hB4
`define IRQ_CLEAR_OFF 8'hB8
`define LAST_HITS_OFF 8'hBC

// ----------------------------------------------------------------------
// Field positions and values.
// ----------------------------------------------------------------------
`define STD_ID_MSB 15
`define STD_ID_LSB 5
`define FRAME_TYPE_SELECT_BIT 3
`define ID_TYPE_MATCH_MODE_BIT 3
`define EXT_HI_MSB 1
`define EXT_HI_LSB 0
`define STD_ID_WMASK 16'hFFEB
`define MASK_SEL_DISABLED 2'h3
`define IRQ_OVF_BIT 0
`define IRQ_ACCEPT_BIT 1
`define IRQ_REJECT_BIT 2

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define OVF_RESET 32'h00000000
`define IRQ_RESET 3'h0
`define MASK_SEL_RESET 32'hFFFFFFFF

`endif

// ---- rtl/can_rx_pkg.sv ----
package can_rx_pkg;
	typedef logic [15:0] reg16_t;
	typedef reg16_t [15:0] filt_bank_t;
	typedef reg16_t [2:0] mask_bank_t;
	typedef logic [1:0] mask_sel_t;
	typedef mask_sel_t [15:0] sel_bank_t;
	typedef logic [2:0] irq_vec_t;
endpackage : can_rx_pkg

// ---- rtl/filter_match.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_consts.svh"

module filter_match (
	input wire can_rx_pkg::filt_bank_t filt_std,
	input wire can_rx_pkg::filt_bank_t filt_ext,
	input wire can_rx_pkg::mask_bank_t mask_std,
	input wire can_rx_pkg::mask_bank_t mask_ext,
	input wire can_rx_pkg::sel_bank_t mask_sel,
	input wire logic [10:0] std_id_bits,
	input wire logic [17:0] ext_id_bits,
	input wire logic frame_ext,
	output logic [15:0] hits
);
	import can_rx_pkg::*;

	// A cleared mask bit never causes a mismatch.
	function automatic logic masked_eq(input logic [17:0] a, input logic [17:0] b,
		input logic [17:0] m);
		return ((a ^ b) & m) == 18'h00000;
	endfunction : masked_eq

	always_comb begin
		reg16_t ms;
		reg16_t me;
		reg16_t fs;
		logic type_ok;
		logic std_ok;
		logic ext_ok;
		ms = 16'h0000;
		me = 16'h0000;
		fs = 16'h0000;
		type_ok = 1'b0;
		std_ok = 1'b0;
		ext_ok = 1'b0;
		hits = 16'h0000;
		for (int f = 0; f < 16; f++) begin
			if (mask_sel[f] != `MASK_SEL_DISABLED) begin
				ms = mask_std[mask_sel[f]];
				me = mask_ext[mask_sel[f]];
				fs = filt_std[f];
				type_ok = !ms[`ID_TYPE_MATCH_MODE_BIT] ||
					(fs[`FRAME_TYPE_SELECT_BIT] == frame_ext);
				std_ok = masked_eq({7'h00, std_id_bits},
					{7'h00, fs[`STD_ID_MSB:`STD_ID_LSB]},
					{7'h00, ms[`STD_ID_MSB:`STD_ID_LSB]});
				ext_ok = !frame_ext || masked_eq(ext_id_bits,
					{fs[`EXT_HI_MSB:`EXT_HI_LSB], filt_ext[f]},
					{ms[`EXT_HI_MSB:`EXT_HI_LSB], me});
				hits[f] = type_ok && std_ok && ext_ok;
			end
		end
	end
endmodule : filter_match
`default_nettype wire

// ---- rtl/can_rx_acceptance_filter.sv ----
// Functional notes
// - Filter bits 15:5 hold compared standard identifier.
// - Filter bits 1:0 hold extended identifier 17:16.
// - Mode set: frame type bit selects frame kind.
// - Mode clear: frame type bit is ignored.
// - Three masks, each standard and extended register.
// - Mask bit one includes identifier bit in compare.
// - Mask bit zero makes identifier bit don't-care.
// - Standard register bits 4 and 2 read zero; code clears them on write only, so they are unknown until first written.
// - Store into full buffer sets overflow flag.
// - Overflow flags clear only by writing zero.
// - Flags 0-15 low register, 16-31 high register.
// - Sixteen filters, each with standard identifier register.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_consts.svh"

module can_rx_acceptance_filter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclken,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [10:0] rx_std_id_bits,
	input wire logic [17:0] rx_ext_id_bits,
	input wire logic rx_frame_ext,
	output logic accept_valid,
	output logic reject_valid,
	output logic [15:0] accept_hits,
	output logic [3:0] accept_filter,
	input wire logic store_req,
	input wire logic [4:0] store_buf,
	input wire logic [31:0] buf_full,
	output logic irq
);
	import can_rx_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------------
	// Storage.
	// ------------------------------------------------------------------
	filt_bank_t filt_std_r;
	filt_bank_t filt_ext_r;
	mask_bank_t mask_std_r;
	mask_bank_t mask_ext_r;
	sel_bank_t mask_sel_r;
	logic [31:0] rx_buffer_overrun_flag_r;
	logic [31:0] rx_buffer_overrun_flag_nxt;
	irq_vec_t irq_sts_r;
	irq_vec_t irq_sts_nxt;
	irq_vec_t irq_en_r;
	irq_vec_t irq_ev;
	logic irq_r;
	logic [15:0] hits_r;
	logic [3:0] first_r;
	logic accept_r;
	logic reject_r;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pslverr_r;
	logic pslverr_nxt;
	logic [15:0] hits;
	logic [31:0] set_vec;
	logic wr_en;
	logic rd_load;
	logic rx_ev;

	// ------------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------------
	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] lo,
		input logic [7:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_bank

	function automatic logic [3:0] word_idx(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		return d[5:2];
	endfunction : word_idx

	function automatic logic [3:0] lowest(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : lowest

	// ------------------------------------------------------------------
	// Acceptance compare.
	// ------------------------------------------------------------------
	filter_match u_match (
		.filt_std(filt_std_r),
		.filt_ext(filt_ext_r),
		.mask_std(mask_std_r),
		.mask_ext(mask_ext_r),
		.mask_sel(mask_sel_r),
		.std_id_bits(rx_std_id_bits),
		.ext_id_bits(rx_ext_id_bits),
		.frame_ext(rx_frame_ext),
		.hits(hits)
	);

	assign rx_ev = pclken && rx_valid;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hits_r <= 16'h0000;
			first_r <= 4'h0;
			accept_r <= 1'b0;
			reject_r <= 1'b0;
		end else if (pclken) begin
			accept_r <= rx_valid && (hits != 16'h0000);
			reject_r <= rx_valid && (hits == 16'h0000);
			if (rx_valid) begin
				hits_r <= hits;
				first_r <= lowest(hits);
			end
		end
	end

	// ------------------------------------------------------------------
	// APB slave: one wait state, write commits at the pready edge.
	// ------------------------------------------------------------------
	assign wr_en = pclken && psel && penable && pready_r && pwrite;
	assign rd_load = pclken && psel && penable && !pready_r;

	always_comb begin
		prdata_nxt = 32'h00000000;
		pslverr_nxt = 1'b0;
		if (in_bank(paddr, `FILT_STD_BASE, `FILT_STD_LAST)) begin
			prdata_nxt = {16'h0000, filt_std_r[word_idx(paddr, `FILT_STD_BASE)]};
		end else if (in_bank(paddr, `FILT_EXT_BASE, `FILT_EXT_LAST)) begin
			prdata_nxt = {16'h0000, filt_ext_r[word_idx(paddr, `FILT_EXT_BASE)]};
		end else if (in_bank(paddr, `MASK_STD_BASE, `MASK_STD_LAST)) begin
			prdata_nxt = {16'h0000, mask_std_r[word_idx(paddr, `MASK_STD_BASE)]};
		end else if (in_bank(paddr, `MASK_EXT_BASE, `MASK_EXT_LAST)) begin
			prdata_nxt = {16'h0000, mask_ext_r[word_idx(paddr, `MASK_EXT_BASE)]};
		end else begin
			unique case (paddr)
				`MASK_SEL_OFF: prdata_nxt = mask_sel_r;
				`OVF_LOW_OFF: prdata_nxt = {16'h0000, rx_buffer_overrun_flag_r[15:0]};
				`OVF_HIGH_OFF: prdata_nxt = {16'h0000, rx_buffer_overrun_flag_r[31:16]};
				`IRQ_STATUS_OFF: prdata_nxt = {29'h00000000, irq_sts_r};
				`IRQ_ENABLE_OFF: prdata_nxt = {29'h00000000, irq_en_r};
				`IRQ_CLEAR_OFF: prdata_nxt = 32'h00000000;
				`LAST_HITS_OFF: prdata_nxt = {12'h000, first_r, hits_r};
				default: pslverr_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (pclken) begin
			pready_r <= psel && penable && !pready_r;
			if (rd_load) begin
				prdata_r <= pwrite ? 32'h00000000 : prdata_nxt;
				pslverr_r <= pslverr_nxt;
			end else begin
				pslverr_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Identifier registers, left unreset on purpose.
	// ------------------------------------------------------------------
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			if (in_bank(paddr, `FILT_STD_BASE, `FILT_STD_LAST)) begin
				filt_std_r[word_idx(paddr, `FILT_STD_BASE)] <=
					pwdata[15:0] & `STD_ID_WMASK;
			end
			if (in_bank(paddr, `FILT_EXT_BASE, `FILT_EXT_LAST)) begin
				filt_ext_r[word_idx(paddr, `FILT_EXT_BASE)] <= pwdata[15:0];
			end
			if (in_bank(paddr, `MASK_STD_BASE, `MASK_STD_LAST)) begin
				mask_std_r[word_idx(paddr, `MASK_STD_BASE)] <=
					pwdata[15:0] & `STD_ID_WMASK;
			end
			if (in_bank(paddr, `MASK_EXT_BASE, `MASK_EXT_LAST)) begin
				mask_ext_r[word_idx(paddr, `MASK_EXT_BASE)] <= pwdata[15:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_sel_r <= `MASK_SEL_RESET;
		end else if (wr_en && (paddr == `MASK_SEL_OFF)) begin
			mask_sel_r <= pwdata;
		end
	end

	// ------------------------------------------------------------------
	// Overflow flags: hardware set beats a software clear.
	// ------------------------------------------------------------------
	assign set_vec = store_req ? (buf_full & (32'h00000001 << store_buf)) : 32'h00000000;

	always_comb begin
		rx_buffer_overrun_flag_nxt = rx_buffer_overrun_flag_r;
		if (wr_en && (paddr == `OVF_LOW_OFF)) begin
			rx_buffer_overrun_flag_nxt[15:0] = rx_buffer_overrun_flag_r[15:0] & pwdata[15:0];
		end
		if (wr_en && (paddr == `OVF_HIGH_OFF)) begin
			rx_buffer_overrun_flag_nxt[31:16] = rx_buffer_overrun_flag_r[31:16] & pwdata[15:0];
		end
		rx_buffer_overrun_flag_nxt = rx_buffer_overrun_flag_nxt | set_vec;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buffer_overrun_flag_r <= `OVF_RESET;
		end else if (pclken) begin
			rx_buffer_overrun_flag_r <= rx_buffer_overrun_flag_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status, enable and clear.
	// ------------------------------------------------------------------
	always_comb begin
		irq_ev = `IRQ_RESET;
		irq_ev[`IRQ_OVF_BIT] = set_vec != 32'h00000000;
		irq_ev[`IRQ_ACCEPT_BIT] = rx_valid && (hits != 16'h0000);
		irq_ev[`IRQ_REJECT_BIT] = rx_valid && (hits == 16'h0000);
		irq_sts_nxt = irq_sts_r;
		if (wr_en && (paddr == `IRQ_CLEAR_OFF)) begin
			irq_sts_nxt = irq_sts_r & ~pwdata[2:0];
		end
		irq_sts_nxt = irq_sts_nxt | irq_ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_sts_r <= `IRQ_RESET;
			irq_r <= 1'b0;
		end else if (pclken) begin
			irq_sts_r <= irq_sts_nxt;
			irq_r <= (irq_sts_nxt & ((wr_en && (paddr == `IRQ_ENABLE_OFF)) ?
				pwdata[2:0] : irq_en_r)) != `IRQ_RESET;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_r <= `IRQ_RESET;
		end else if (wr_en && (paddr == `IRQ_ENABLE_OFF)) begin
			irq_en_r <= pwdata[2:0];
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign accept_valid = accept_r;
	assign reject_valid = reject_r;
	assign accept_hits = hits_r;
	assign accept_filter = first_r;
	assign irq = irq_r;

	// ------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------
	logic [15:0] f0;
	logic [15:0] m0;
	logic [15:0] e0;
	logic f0_on;
	assign f0 = filt_std_r[0];
	assign f0_on = mask_sel_r[0] != `MASK_SEL_DISABLED;
	assign m0 = f0_on ? mask_std_r[mask_sel_r[0]] : 16'h0000;
	assign e0 = f0_on ? mask_ext_r[mask_sel_r[0]] : 16'h0000;

	property p_std_mismatch;
		rx_ev && f0_on && m0[`STD_ID_MSB] && (rx_std_id_bits[10] != f0[`STD_ID_MSB])
			|=> !hits_r[0] && !(accept_r && (first_r == 4'h0));
	endproperty
	a_std_mismatch: assert property (p_std_mismatch) else $error("std bit mismatch hit");

	property p_ext_hi_mismatch;
		rx_ev && f0_on && rx_frame_ext && m0[`EXT_HI_LSB] &&
			(rx_ext_id_bits[16] != f0[`EXT_HI_LSB]) |=> !hits_r[0];
	endproperty
	a_ext_hi_mismatch: assert property (p_ext_hi_mismatch) else $error("ext hi mismatch hit");

	property p_type_restrict;
		rx_ev && f0_on && m0[`ID_TYPE_MATCH_MODE_BIT] &&
			(f0[`FRAME_TYPE_SELECT_BIT] != rx_frame_ext) |=> !hits_r[0];
	endproperty
	a_type_restrict: assert property (p_type_restrict) else $error("wrong frame type hit");

	property p_all_dont_care;
		rx_ev && f0_on && (m0 == 16'h0000) && (e0 == 16'h0000)
			|=> hits_r[0] && accept_r ##1 (!accept_r || $past(rx_valid) || !$past(pclken));
	endproperty
	a_all_dont_care: assert property (p_all_dont_care) else $error("open mask missed");

	property p_ext_lo_mismatch;
		rx_ev && f0_on && rx_frame_ext && e0[0] &&
			(rx_ext_id_bits[0] != filt_ext_r[0][0]) |=> !hits_r[0];
	endproperty
	a_ext_lo_mismatch: assert property (p_ext_lo_mismatch) else $error("ext lo mismatch hit");

	property p_ovf_set;
		pclken && store_req && buf_full[store_buf]
			|=> rx_buffer_overrun_flag_r[$past(store_buf)] && irq_sts_r[`IRQ_OVF_BIT];
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

	property p_ovf_no_fall;
		!$past(wr_en) |-> (rx_buffer_overrun_flag_r & $past(rx_buffer_overrun_flag_r))
			== $past(rx_buffer_overrun_flag_r);
	endproperty
	a_ovf_no_fall: assert property (p_ovf_no_fall) else $error("flag cleared without write");

	property p_ovf_read;
		pready_r && psel && !pwrite && (paddr == `OVF_HIGH_OFF) && !$past(store_req)
			|-> prdata_r == {16'h0000, $past(rx_buffer_overrun_flag_r[31:16])};
	endproperty
	a_ovf_read: assert property (p_ovf_read) else $error("high flag read wrong");

	property p_unimpl_zero;
		pready_r && psel && !pwrite && (in_bank(paddr, `FILT_STD_BASE, `FILT_STD_LAST) ||
			in_bank(paddr, `MASK_STD_BASE, `MASK_STD_LAST))
			|-> (prdata_r[4] == 1'b0) && (prdata_r[2] == 1'b0);
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("reserved bit read one");

	property p_irq_level;
		##1 irq_r == ((irq_sts_r & irq_en_r) != `IRQ_RESET) || !$past(pclken);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	c_accept: cover property (rx_ev ##1 accept_r);
	c_reject: cover property (rx_ev ##1 reject_r);
	c_ovf_clear: cover property (rx_buffer_overrun_flag_r[0] ##1 !rx_buffer_overrun_flag_r[0]);
	c_irq: cover property ($rose(irq_r));
endmodule : can_rx_acceptance_filter
`default_nettype wire

// ---- dv/can_node_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module can_node_model (
	input wire logic pclk,
	output logic rx_valid,
	output logic [10:0] rx_std_id_bits,
	output logic [17:0] rx_ext_id_bits,
	output logic rx_frame_ext,
	output logic store_req,
	output logic [4:0] store_buf,
	output logic [31:0] buf_full
);
	initial begin
		rx_valid = 1'h0;
		rx_std_id_bits = 11'h0;
		rx_ext_id_bits = 18'h0;
		rx_frame_ext = 1'h0;
		store_req = 1'h0;
		store_buf = 5'h0;
		buf_full = 32'h0;
	end

	// After a pulse the lines carry the inverse of the last value.
	task automatic send(input logic [10:0] s, input logic [17:0] e, input logic x);
		@(posedge pclk);
		rx_valid <= 1'h1;
		rx_std_id_bits <= s;
		rx_ext_id_bits <= e;
		rx_frame_ext <= x;
		@(posedge pclk);
		rx_valid <= 1'h0;
		rx_std_id_bits <= ~s;
		rx_ext_id_bits <= ~e;
		rx_frame_ext <= ~x;
	endtask : send

	// A store attempt; when the target is not full, every other buffer is.
	task automatic store(input logic [4:0] b, input logic f);
		@(posedge pclk);
		store_req <= 1'h1;
		store_buf <= b;
		buf_full <= f ? (32'h1 << b) : ~(32'h1 << b);
		@(posedge pclk);
		store_req <= 1'h0;
		store_buf <= ~b;
	endtask : store
endmodule : can_node_model

`default_nettype wire

// ---- dv/can_rx_acceptance_filter_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module can_rx_acceptance_filter_tb_top;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, rx_valid, rx_frame_ext, accept_valid, reject_valid, store_req, irq;
	logic [10:0] rx_std_id_bits;
	logic [17:0] rx_ext_id_bits;
	logic [15:0] accept_hits;
	logic [3:0] accept_filter;
	logic [4:0] store_buf;
	logic [31:0] buf_full, q;
	logic er;
	logic pclken = 1'h1;
	int num_errors = 0;
	int comparisons = 0;

	always #5 pclk = ~pclk;

	can_rx_acceptance_filter can_rx_acceptance_filter_i (.pclk(pclk), .presetn(presetn),
		.pclken(pclken), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_valid(rx_valid), .rx_std_id_bits(rx_std_id_bits), .rx_ext_id_bits(rx_ext_id_bits),
		.rx_frame_ext(rx_frame_ext), .accept_valid(accept_valid), .reject_valid(reject_valid),
		.accept_hits(accept_hits), .accept_filter(accept_filter), .store_req(store_req),
		.store_buf(store_buf), .buf_full(buf_full), .irq(irq));

	can_node_model can_node_model_i (.pclk(pclk), .rx_valid(rx_valid),
		.rx_std_id_bits(rx_std_id_bits), .rx_ext_id_bits(rx_ext_id_bits),
		.rx_frame_ext(rx_frame_ext), .store_req(store_req), .store_buf(store_buf),
		.buf_full(buf_full));

	// ----------------------------------------------------------------------
	// Helper tasks.
	// ----------------------------------------------------------------------
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'h1) break;
		end
		q = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (i == 16) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask : wr

	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(n, e, q);
	endtask : rdc

	task automatic fr(input logic [10:0] s, input logic [17:0] e, input logic x,
		input logic [15:0] h);
		int i;
		can_node_model_i.send(s, e, x);
		#1;
		for (i = 0; i < 4 && accept_valid !== 1'h1 && reject_valid !== 1'h1; i++) begin
			@(posedge pclk);
			#1;
		end
		if (accept_valid !== 1'h1 && reject_valid !== 1'h1) begin
			num_errors++;
			tally_and_finish();
		end
		chk("accept", {31'h0, |h}, {31'h0, accept_valid});
		chk("reject", {31'h0, ~|h}, {31'h0, reject_valid});
		chk("hits", {16'h0, h}, {16'h0, accept_hits});
	endtask : fr

	// ----------------------------------------------------------------------
	// Test sequence.
	// ----------------------------------------------------------------------
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		rdc("ovf_low", 8'hA4, 32'h0);
		rdc("ovf_high", 8'hA8, 32'h0);
		rdc("mask_sel", 8'hA0, 32'hFFFFFFFF);
		fr(11'h123, 18'h0, 1'h0, 16'h0);
		$display("test reset done");
		wr(8'h04, 32'hFFFF);
		rdc("filter_std", 8'h04, 32'hFFEB);
		wr(8'h84, 32'hFFFF);
		rdc("mask_std", 8'h84, 32'hFFEB);
		wr(8'h94, 32'hFFFF);
		rdc("mask_ext", 8'h94, 32'hFFFF);
		$display("test registers done");
		wr(8'h00, 32'h246A);
		wr(8'h40, 32'h00A5);
		rdc("filter_ext", 8'h40, 32'h00A5);
		wr(8'h80, 32'hFFEB);
		wr(8'h90, 32'hFFFF);
		wr(8'hA0, 32'hFFFFFFFC);
		fr(11'h123, 18'h200A5, 1'h1, 16'h0001);
		chk("filter", 32'h0, {28'h0, accept_filter});
		fr(11'h123, 18'h200A5, 1'h0, 16'h0);
		fr(11'h123, 18'h200A4, 1'h1, 16'h0);
		fr(11'h123, 18'h100A5, 1'h1, 16'h0);
		fr(11'h122, 18'h200A5, 1'h1, 16'h0);
		wr(8'h80, 32'hFFE3);
		fr(11'h123, 18'h0, 1'h0, 16'h0001);
		wr(8'h80, 32'hFFC3);
		fr(11'h122, 18'h0, 1'h0, 16'h0001);
		wr(8'h90, 32'hFFFE);
		fr(11'h123, 18'h200A4, 1'h1, 16'h0001);
		wr(8'h3C, 32'hFFE0);
		wr(8'h88, 32'hFFE0);
		wr(8'h98, 32'h0);
		wr(8'hA0, 32'hBFFFFFFC);
		fr(11'h7FF, 18'h0, 1'h0, 16'h8000);
		chk("filter", 32'hF, {28'h0, accept_filter});
		rdc("last_hits", 8'hBC, 32'h000F8000);
		wr(8'h80, 32'h0);
		wr(8'h90, 32'h0);
		fr(11'h555, 18'h3FFFF, 1'h1, 16'h0001);
		$display("test filtering done");
		rdc("irq_status", 8'hB0, 32'h6);
		wr(8'hB8, 32'h7);
		wr(8'hB4, 32'h1);
		can_node_model_i.store(5'd5, 1'h1);
		can_node_model_i.store(5'd20, 1'h1);
		can_node_model_i.store(5'd7, 1'h0);
		rdc("ovf_low", 8'hA4, 32'h0020);
		rdc("ovf_high", 8'hA8, 32'h0010);
		chk("irq", 32'h1, {31'h0, irq});
		wr(8'hA4, 32'hFFFF);
		rdc("ovf_low", 8'hA4, 32'h0020);
		wr(8'hA4, 32'hFFDF);
		rdc("ovf_low", 8'hA4, 32'h0);
		rdc("ovf_high", 8'hA8, 32'h0010);
		wr(8'hB8, 32'h7);
		rdc("irq_status", 8'hB0, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(8'hB4, 32'h0);
		can_node_model_i.store(5'd3, 1'h1);
		rdc("irq_status", 8'hB0, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		wr(8'hB4, 32'h1);
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		rdc("irq_enable", 8'hB4, 32'h1);
		wr(8'hB8, 32'h7);
		pclken <= 1'h0;
		can_node_model_i.store(5'd9, 1'h1);
		pclken <= 1'h1;
		rdc("ovf_low", 8'hA4, 32'h0008);
		rdc("irq_status", 8'hB0, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test overflow done");
		bus(1'h1, 8'hC0, 32'hFFFF);
		chk("slverr", 32'h1, {31'h0, er});
		bus(1'h0, 8'hC0, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		chk("unmapped", 32'h0, q);
		$display("test unmapped done");
		tally_and_finish();
	end
endmodule : can_rx_acceptance_filter_tb_top

`default_nettype wire
